// *** flash_ctrl_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module flash_ctrl_regs
  import flash_ctrl_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [15:0] wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  input  wire logic        hwResetInN,
  input  wire logic        resetModeActive,
  input  wire logic [5:0]  sourceEvents,
  input  wire logic        downloadActive,
  input  wire logic        downloadDone,
  input  wire logic        ifCfgPin,
  input  wire logic        deepSleepPin,
  input  wire logic        sleepRequest,
  input  wire logic        deviceIdle,
  output logic             busyN,
  output logic             upperPullupEnable,
  output logic             fastOutputEnable,
  output logic             deepSleepActive,
  output logic             hostIrqN,
  output logic             irq
);

  // ==========================================================
  // Internal state
  // ==========================================================
  logic [5:0]      srcEnable;
  logic [5:0]      srcMask;
  logic            irqGlobalGate;
  logic            busyEnable;
  logic            upperPullupOff;
  logic            turboEnable;
  logic            hwDownload;
  logic [3:0]      pdMode;
  logic            sleepAllowedFlag;
  power_state_type powerState;
  power_state_type next_powerState;
  logic [7:0]      eventStatus;
  logic [7:0]      eventMask;
  logic [7:0]      eventSet;
  logic [31:0]     readData;
  logic            busWrite;
  logic            pinRise;
  logic            pinFall;
  logic [5:0]      flagRise;

  irq_flag_if flagBus ();

  assign flagBus.source = sourceEvents;
  assign flagBus.enable = srcEnable;

  sticky_flags u_flags (
    .sys_clk (sys_clk),
    .reset   (reset),
    .bus     (flagBus.latch)
  );

  pin_edge #(.WIDTH(1)) u_pin_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .level   (deepSleepPin),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  pin_edge #(.WIDTH(SRC_COUNT)) u_flag_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .level   (flagBus.flags),
    .rise    (flagRise),
    .fall    ()
  );

  // ==========================================================
  // Wishbone slave: one wait state, write commits on the ack edge
  // ==========================================================
  assign busWrite = wbCyc & wbStb & wbWe & wbAck & wbSel[0];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wbAck  <= 1'b0;
      wbDatO <= 32'h00000000;
    end else begin
      wbAck  <= wbCyc & wbStb & ~wbAck;
      wbDatO <= readData;
    end
  end

  // Unmapped words and reserved bits read as zero
  always_comb begin
    readData = 32'h00000000;
    unique case ({wbAdr[15:2], 2'b00})
      ADDR_SOURCE_CONTROL: begin
        readData[SRC_ENABLE_LSB +: SRC_COUNT] = srcEnable;
        readData[SRC_MASK_LSB +: SRC_COUNT]   = srcMask;
        readData[GLOBAL_GATE_BIT]             = irqGlobalGate;
      end
      ADDR_SOURCE_FLAGS: begin
        readData[SRC_COUNT-1:0] = flagBus.flags;
      end
      ADDR_OUTPUT_CTRL: begin
        readData[BUSY_ENABLE_BIT] = busyEnable;
        readData[PULLUP_OFF_BIT]  = upperPullupOff;
        readData[TURBO_BIT]       = turboEnable;
      end
      ADDR_POWERDOWN_CTRL: begin
        readData[MODE_LSB +: MODE_WIDTH] = pdMode;
        readData[SLEEP_OK_BIT]           = sleepAllowedFlag;
      end
      ADDR_EVENT_STATUS: begin
        readData[EVENT_COUNT-1:0] = eventStatus;
      end
      ADDR_EVENT_MASK: begin
        readData[EVENT_COUNT-1:0] = eventMask;
      end
      default: readData = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Interrupt source control
  // ==========================================================
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      srcEnable     <= SRC_RESET;
      srcMask       <= SRC_RESET;
      irqGlobalGate <= 1'b0;
    end else if (busWrite && {wbAdr[15:2], 2'b00} == ADDR_SOURCE_CONTROL) begin
      srcEnable <= wbDatI[SRC_ENABLE_LSB +: SRC_COUNT];
      if (wbSel[1]) begin
        srcMask       <= wbDatI[SRC_MASK_LSB +: SRC_COUNT];
        irqGlobalGate <= wbDatI[GLOBAL_GATE_BIT];
      end
    end
  end

  // Request pin needs the global gate and the per-source mask
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hostIrqN <= 1'b1;
    end else begin
      hostIrqN <= ~(irqGlobalGate & |(flagBus.flags & srcMask));
    end
  end

  // ==========================================================
  // Output control: survives the internal reset mode
  // ==========================================================
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busyEnable     <= OUTPUT_CTRL_RESET[BUSY_ENABLE_BIT];
      upperPullupOff <= OUTPUT_CTRL_RESET[PULLUP_OFF_BIT];
      turboEnable    <= OUTPUT_CTRL_RESET[TURBO_BIT];
    end else if (!hwResetInN) begin
      busyEnable     <= OUTPUT_CTRL_RESET[BUSY_ENABLE_BIT];
      upperPullupOff <= OUTPUT_CTRL_RESET[PULLUP_OFF_BIT];
      turboEnable    <= OUTPUT_CTRL_RESET[TURBO_BIT];
    end else if (busWrite && {wbAdr[15:2], 2'b00} == ADDR_OUTPUT_CTRL) begin
      // No cascade position compare: every device in a chain takes the write
      busyEnable     <= wbDatI[BUSY_ENABLE_BIT];
      upperPullupOff <= wbDatI[PULLUP_OFF_BIT];
      turboEnable    <= wbDatI[TURBO_BIT];
    end
  end

  // Download started by the hardware reset pin ignores the gate bit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hwDownload <= 1'b0;
    end else if (!hwResetInN) begin
      hwDownload <= 1'b1;
    end else if (downloadDone) begin
      hwDownload <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busyN             <= 1'b1;
      upperPullupEnable <= 1'b0;
      fastOutputEnable  <= 1'b0;
    end else begin
      busyN             <= ~(downloadActive & (hwDownload | busyEnable));
      upperPullupEnable <= ~upperPullupOff & ~ifCfgPin;
      fastOutputEnable  <= turboEnable;
    end
  end

  // ==========================================================
  // Deep power-down control
  // ==========================================================
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pdMode <= POWERDOWN_RESET[MODE_LSB +: MODE_WIDTH];
    end else if (resetModeActive) begin
      pdMode <= POWERDOWN_RESET[MODE_LSB +: MODE_WIDTH];
    end else if (busWrite && {wbAdr[15:2], 2'b00} == ADDR_POWERDOWN_CTRL) begin
      pdMode <= wbDatI[MODE_LSB +: MODE_WIDTH];
    end
  end

  // Not allowed while a boot download is still running
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleepAllowedFlag <= 1'b0;
    end else begin
      sleepAllowedFlag <= deviceIdle & ~downloadActive;
    end
  end

  // Edge and unused-pin modes enter on the controller's request;
  // an unlisted mode code wakes the device rather than trap it asleep.
  always_comb begin
    next_powerState = powerState;
    unique case (powerState)
      PWR_AWAKE: begin
        if (pdMode == MODE_LEVEL_HIGH) begin
          if (deepSleepPin) next_powerState = PWR_ASLEEP;
        end else if (pdMode == MODE_LEVEL_LOW) begin
          if (!deepSleepPin) next_powerState = PWR_ASLEEP;
        end else if (sleepRequest && sleepAllowedFlag) begin
          next_powerState = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        if (pdMode == MODE_PIN_UNUSED) begin
          if (!sleepRequest) next_powerState = PWR_AWAKE;
        end else if (pdMode == MODE_EXIT_RISE) begin
          if (pinRise) next_powerState = PWR_AWAKE;
        end else if (pdMode == MODE_EXIT_FALL) begin
          if (pinFall) next_powerState = PWR_AWAKE;
        end else if (pdMode == MODE_LEVEL_HIGH) begin
          if (!deepSleepPin) next_powerState = PWR_AWAKE;
        end else if (pdMode == MODE_LEVEL_LOW) begin
          if (deepSleepPin) next_powerState = PWR_AWAKE;
        end else begin
          next_powerState = PWR_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      powerState      <= PWR_AWAKE;
      deepSleepActive <= 1'b0;
    end else begin
      powerState      <= next_powerState;
      deepSleepActive <= (next_powerState == PWR_ASLEEP);
    end
  end

  // ==========================================================
  // Event status (write one to clear) and interrupt output
  // ==========================================================
  always_comb begin
    eventSet                   = {2'b00, flagRise};
    eventSet[EVT_SLEEP_IN_BIT] = (powerState == PWR_AWAKE) && (next_powerState == PWR_ASLEEP);
    eventSet[EVT_WAKE_BIT]     = (powerState == PWR_ASLEEP) && (next_powerState == PWR_AWAKE);
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      eventStatus <= EVENT_RESET;
    end else if (busWrite && {wbAdr[15:2], 2'b00} == ADDR_EVENT_STATUS) begin
      eventStatus <= (eventStatus & ~wbDatI[EVENT_COUNT-1:0]) | eventSet;
    end else begin
      eventStatus <= eventStatus | eventSet;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      eventMask <= EVENT_RESET;
    end else if (busWrite && {wbAdr[15:2], 2'b00} == ADDR_EVENT_MASK) begin
      eventMask <= wbDatI[EVENT_COUNT-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus & eventMask);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  flag_latch_a: assert property ((srcEnable & sourceEvents) != 6'h00 |=>
    (flagBus.flags & $past(srcEnable & sourceEvents)) == $past(srcEnable & sourceEvents))
    else $error("enabled source event was not latched");
  reserved_zero_a: assert property (wbAck |-> wbDatO[31:16] == 16'h0000)
    else $error("reserved upper bits read nonzero");
  hw_reset_default_a: assert property (!hwResetInN |=> busyEnable && !turboEnable)
    else $error("hardware reset did not restore output control");

  reset_mode_keep_a: assert property (resetModeActive && hwResetInN && !busWrite |=>
    $stable(busyEnable) && $stable(turboEnable) && $stable(upperPullupOff))
    else $error("reset mode altered output control");

  busy_hold_a: assert property (hwDownload && downloadActive |=> !busyN)
    else $error("busy not held during hardware-reset download");
  busy_gate_a: assert property (downloadActive && !hwDownload && !busyEnable |=> busyN)
    else $error("busy asserted while gated off");

  pullup_cfg_a: assert property (ifCfgPin || upperPullupOff |=> !upperPullupEnable)
    else $error("upper pull-ups enabled when they must be off");
  turbo_write_a: assert property (busWrite && hwResetInN &&
    {wbAdr[15:2], 2'b00} == ADDR_OUTPUT_CTRL |=> ##1 fastOutputEnable == $past(wbDatI[TURBO_BIT], 2))
    else $error("turbo output enable does not follow the write");

  edge_exit_a: assert property (powerState == PWR_ASLEEP && pdMode == MODE_EXIT_RISE &&
    pinRise |=> !deepSleepActive)
    else $error("rising edge did not leave power-down");

  level_enter_a: assert property (powerState == PWR_AWAKE && pdMode == MODE_LEVEL_HIGH &&
    deepSleepPin |=> deepSleepActive)
    else $error("high pin level did not enter power-down");

  sleep_flag_a: assert property (!deviceIdle |=> !sleepAllowedFlag)
    else $error("power-down reported allowed while busy");
  disabled_clear_a: assert property (##1 (flagBus.flags & ~$past(srcEnable)) == 6'h00)
    else $error("flag set on a disabled source");

  irq_gate_a: assert property (!irqGlobalGate |=> hostIrqN)
    else $error("request pin asserted with global gate off");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

  hw_download_c: cover property (!hwResetInN ##1 hwResetInN ##[1:20] !busyN);
  sleep_cycle_c: cover property (!deepSleepActive ##1 deepSleepActive ##[1:50] !deepSleepActive);
  host_irq_c:    cover property ($fell(hostIrqN));
  event_irq_c:   cover property ($rose(irq));

endmodule : flash_ctrl_regs

`default_nettype wire

// *** flash_ctrl_regs_pkg.sv ***
package flash_ctrl_regs_pkg;

  // ==========================================================
  // Register map (byte addresses, 32-bit aligned words)
  // ==========================================================
  localparam logic [15:0] ADDR_SOURCE_CONTROL = 16'h1070;
  localparam logic [15:0] ADDR_SOURCE_FLAGS   = 16'h1074;
  localparam logic [15:0] ADDR_POWERDOWN_CTRL = 16'h107c;
  localparam logic [15:0] ADDR_OUTPUT_CTRL    = 16'h1080;
  localparam logic [15:0] ADDR_EVENT_STATUS   = 16'h1084;
  localparam logic [15:0] ADDR_EVENT_MASK     = 16'h1088;

  localparam int ADDR_WIDTH  = 16;
  localparam int DATA_WIDTH  = 32;
  localparam int SEL_WIDTH   = 4;
  localparam int SRC_COUNT   = 6;
  localparam int EVENT_COUNT = 8;
  localparam int MODE_WIDTH  = 4;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int SRC_ENABLE_LSB   = 0;
  localparam int SRC_MASK_LSB     = 8;
  localparam int GLOBAL_GATE_BIT  = 15;
  localparam int BUSY_ENABLE_BIT  = 0;
  localparam int PULLUP_OFF_BIT   = 1;
  localparam int TURBO_BIT        = 2;
  localparam int MODE_LSB         = 0;
  localparam int SLEEP_OK_BIT     = 7;
  localparam int EVT_SLEEP_IN_BIT = 6;
  localparam int EVT_WAKE_BIT     = 7;

  // ==========================================================
  // Reset values and mode codes
  // ==========================================================
  localparam logic [7:0] OUTPUT_CTRL_RESET = 8'h01;
  localparam logic [7:0] POWERDOWN_RESET   = 8'h00;
  localparam logic [7:0] EVENT_RESET       = 8'h00;
  localparam logic [5:0] SRC_RESET         = 6'h00;

  localparam logic [3:0] MODE_PIN_UNUSED = 4'h0;
  localparam logic [3:0] MODE_EXIT_RISE  = 4'h1;
  localparam logic [3:0] MODE_EXIT_FALL  = 4'h2;
  localparam logic [3:0] MODE_LEVEL_HIGH = 4'h4;
  localparam logic [3:0] MODE_LEVEL_LOW  = 4'h8;

  typedef enum logic [0:0] {
    PWR_AWAKE  = 1'b0,
    PWR_ASLEEP = 1'b1
  } power_state_type;

endpackage : flash_ctrl_regs_pkg

// *** host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
  import flash_ctrl_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        wbAck,
  input  wire logic [31:0] wbDatO,
  output logic             wbCyc,
  output logic             wbStb,
  output logic             wbWe,
  output logic      [15:0] wbAdr,
  output logic      [3:0]  wbSel,
  output logic      [31:0] wbDatI
);
  // ====================
  // Idle bus
  // ====================
  initial begin
    wbCyc  = 1'b0;
    wbStb  = 1'b0;
    wbWe   = 1'b0;
    wbAdr  = 16'h0000;
    wbSel  = 4'h0;
    wbDatI = 32'h0000_0000;
  end

  // ====================
  // Classic single cycle
  // ====================
  // Request stays frozen until ack is seen; the entry edge leaves cyc low one cycle
  task automatic access(input logic we, input logic [15:0] adr, input logic [31:0] dat,
                        output logic [31:0] rdat);
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= 4'hf;
    wbDatI <= dat;
    // No local cap: a missing ack is left to the bench watchdog
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    rdat = wbDatO;
    wbCyc  <= 1'b0;
    wbStb  <= 1'b0;
    wbWe   <= 1'b0;
    wbDatI <= ~dat;
  endtask : access

  // A latched flag only drops by taking its enable away and giving it back
  task automatic rearm(input logic [31:0] ctrl, input int idx);
    logic [31:0] unused;
    access(1'b1, ADDR_SOURCE_CONTROL, ctrl & ~(32'h1 << idx), unused);
    access(1'b1, ADDR_SOURCE_CONTROL, ctrl, unused);
  endtask : rearm
endmodule : host_bus_model

`default_nettype wire

// *** irq_flag_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface irq_flag_if;
  logic [5:0] source;
  logic [5:0] enable;
  logic [5:0] flags;

  modport control (output source, output enable, input flags);
  modport latch   (input source, input enable, output flags);
endinterface : irq_flag_if

`default_nettype wire

// *** pin_edge.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] previous;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      previous <= '0;
    end else begin
      previous <= level;
    end
  end

  assign rise = level & ~previous;
  assign fall = ~level & previous;

endmodule : pin_edge

`default_nettype wire

// *** sticky_flags.sv ***
`timescale 1ns/1ps
`default_nettype none

module sticky_flags (
  input wire logic sys_clk,
  input wire logic reset,
  irq_flag_if.latch bus
);

  // A disabled channel is held clear; toggling its enable re-arms it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus.flags <= 6'h00;
    end else begin
      bus.flags <= bus.enable & (bus.flags | bus.source);
    end
  end

endmodule : sticky_flags

`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  import flash_ctrl_regs_pkg::*;

  logic        sys_clk, reset, wbCyc, wbStb, wbWe, wbAck;
  logic [15:0] wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO;
  logic        hwResetInN, resetModeActive, downloadActive, downloadDone;
  logic [5:0]  sourceEvents;
  logic        ifCfgPin, deepSleepPin, sleepRequest, deviceIdle;
  logic        busyN, upperPullupEnable, fastOutputEnable, deepSleepActive, hostIrqN, irq;
  int          badCount = 0;
  int          compares = 0;
  int          cycles = 0;

  flash_ctrl_regs flash_ctrl_regs_inst (.sys_clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatI, .wbDatO, .wbAck, .hwResetInN, .resetModeActive, .sourceEvents,
    .downloadActive, .downloadDone, .ifCfgPin, .deepSleepPin, .sleepRequest, .deviceIdle,
    .busyN, .upperPullupEnable, .fastOutputEnable, .deepSleepActive, .hostIrqN, .irq);

  host_bus_model host_bus_model_inst (.sys_clk, .wbAck, .wbDatO, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatI);

  // ====================
  // Clock and watchdog
  // ====================
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole sequence needs well under 1500 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      badCount++;
      results();
    end
  end

  // ====================
  // Helpers
  // ====================
  task automatic results();
    $display("checks %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord

  task automatic checkBit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : checkBit

  task automatic wr(input logic [15:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    host_bus_model_inst.access(1'b1, adr, dat, unused);
  endtask : wr

  task automatic rd(input logic [15:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] got;
    host_bus_model_inst.access(1'b0, adr, 32'h0, got);
    checkWord(what, exp, got);
  endtask : rd

  // Outputs lag their cause by at most three edges; look at mid-cycle
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic pulse(input int idx);
    @(posedge sys_clk) sourceEvents <= 6'h01 << idx;
    @(posedge sys_clk) sourceEvents <= 6'h00;
    settle();
  endtask : pulse

  // ====================
  // Sequence
  // ====================
  initial begin
    reset = 1'b1;
    hwResetInN = 1'b1;
    resetModeActive = 1'b0;
    sourceEvents = 6'h00;
    downloadActive = 1'b0;
    downloadDone = 1'b0;
    ifCfgPin = 1'b0;
    deepSleepPin = 1'b0;
    sleepRequest = 1'b0;
    deviceIdle = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_OUTPUT_CTRL, 32'h01, "output ctrl reset");
    rd(ADDR_SOURCE_FLAGS, 32'h00, "flags reset");
    rd(ADDR_POWERDOWN_CTRL, 32'h00, "powerdown reset");
    wr(ADDR_OUTPUT_CTRL, 32'hffff_ffff);
    rd(ADDR_OUTPUT_CTRL, 32'h07, "output ctrl reserved");
    @(negedge sys_clk) checkBit("turbo on", 1'b1, fastOutputEnable);
    checkBit("pullup off", 1'b0, upperPullupEnable);
    wr(ADDR_OUTPUT_CTRL, 32'h00);
    settle();
    checkBit("turbo off", 1'b0, fastOutputEnable);
    checkBit("pullup cfg low", 1'b1, upperPullupEnable);
    @(posedge sys_clk) ifCfgPin <= 1'b1;
    settle();
    checkBit("pullup cfg high", 1'b0, upperPullupEnable);
    wr(16'h1090, 32'hffff_ffff);
    rd(16'h1090, 32'h00, "unmapped");
    wr(ADDR_SOURCE_FLAGS, 32'hffff_ffff);
    rd(ADDR_SOURCE_FLAGS, 32'h00, "flags read only");
    // Busy gating during a soft download
    @(posedge sys_clk) downloadActive <= 1'b1;
    settle();
    checkBit("busy gated", 1'b1, busyN);
    wr(ADDR_OUTPUT_CTRL, 32'h01);
    settle();
    checkBit("busy allowed", 1'b0, busyN);
    @(posedge sys_clk) downloadActive <= 1'b0;
    downloadDone <= 1'b1;
    @(posedge sys_clk) downloadDone <= 1'b0;
    settle();
    checkBit("busy done", 1'b1, busyN);
    // Reset mode keeps output control; hardware reset restores it
    wr(ADDR_OUTPUT_CTRL, 32'h06);
    @(posedge sys_clk) resetModeActive <= 1'b1;
    repeat (2) @(posedge sys_clk);
    resetModeActive <= 1'b0;
    rd(ADDR_OUTPUT_CTRL, 32'h06, "output ctrl reset mode");
    @(posedge sys_clk) hwResetInN <= 1'b0;
    downloadActive <= 1'b1;
    @(posedge sys_clk) hwResetInN <= 1'b1;
    settle();
    checkBit("busy hw download", 1'b0, busyN);
    rd(ADDR_OUTPUT_CTRL, 32'h01, "output ctrl hw reset");
    wr(ADDR_OUTPUT_CTRL, 32'h00);
    settle();
    checkBit("busy hw held", 1'b0, busyN);
    @(posedge sys_clk) downloadActive <= 1'b0;
    downloadDone <= 1'b1;
    @(posedge sys_clk) downloadDone <= 1'b0;
    settle();
    checkBit("busy hw done", 1'b1, busyN);
    // Every source latches, requests and re-arms
    wr(ADDR_SOURCE_CONTROL, 32'hbf3f);
    for (int i = 0; i < SRC_COUNT; i++) begin
      pulse(i);
      rd(ADDR_SOURCE_FLAGS, 32'h1 << i, "source flag");
      checkBit("irq pin set", 1'b0, hostIrqN);
      host_bus_model_inst.rearm(32'hbf3f, i);
      rd(ADDR_SOURCE_FLAGS, 32'h00, "flag rearmed");
      checkBit("irq pin clear", 1'b1, hostIrqN);
    end
    rd(ADDR_EVENT_STATUS, 32'h3f, "event status");
    checkBit("irq masked", 1'b0, irq);
    wr(ADDR_EVENT_MASK, 32'h01);
    settle();
    checkBit("irq unmasked", 1'b1, irq);
    wr(ADDR_EVENT_STATUS, 32'h01);
    settle();
    checkBit("irq cleared", 1'b0, irq);
    rd(ADDR_EVENT_STATUS, 32'h3e, "event w1c");
    wr(ADDR_EVENT_STATUS, 32'hff);
    wr(ADDR_EVENT_MASK, 32'h00);
    wr(ADDR_SOURCE_CONTROL, 32'h8001);
    pulse(0);
    rd(ADDR_SOURCE_FLAGS, 32'h01, "flag unmasked src");
    checkBit("irq pin mask off", 1'b1, hostIrqN);
    wr(ADDR_SOURCE_CONTROL, 32'hbf00);
    pulse(1);
    rd(ADDR_SOURCE_FLAGS, 32'h00, "flag disabled src");
    // Sleep allowed flag and pin modes
    @(posedge sys_clk) deviceIdle <= 1'b1;
    rd(ADDR_POWERDOWN_CTRL, 32'h80, "sleep allowed");
    @(posedge sys_clk) downloadActive <= 1'b1;
    rd(ADDR_POWERDOWN_CTRL, 32'h00, "sleep refused");
    @(posedge sys_clk) downloadActive <= 1'b0;
    wr(ADDR_POWERDOWN_CTRL, 32'hff);
    rd(ADDR_POWERDOWN_CTRL, 32'h8f, "powerdown reserved");
    wr(ADDR_POWERDOWN_CTRL, 32'h04);
    @(posedge sys_clk) deepSleepPin <= 1'b1;
    settle();
    checkBit("level high enter", 1'b1, deepSleepActive);
    @(posedge sys_clk) deepSleepPin <= 1'b0;
    settle();
    checkBit("level high leave", 1'b0, deepSleepActive);
    wr(ADDR_POWERDOWN_CTRL, 32'h08);
    settle();
    checkBit("level low enter", 1'b1, deepSleepActive);
    @(posedge sys_clk) deepSleepPin <= 1'b1;
    settle();
    checkBit("level low leave", 1'b0, deepSleepActive);
    wr(ADDR_POWERDOWN_CTRL, 32'h02);
    @(posedge sys_clk) sleepRequest <= 1'b1;
    settle();
    @(posedge sys_clk) sleepRequest <= 1'b0;
    settle();
    checkBit("fall mode held", 1'b1, deepSleepActive);
    @(posedge sys_clk) deepSleepPin <= 1'b0;
    settle();
    checkBit("fall mode exit", 1'b0, deepSleepActive);
    wr(ADDR_POWERDOWN_CTRL, 32'h01);
    @(posedge sys_clk) sleepRequest <= 1'b1;
    settle();
    @(posedge sys_clk) sleepRequest <= 1'b0;
    settle();
    checkBit("rise mode held", 1'b1, deepSleepActive);
    @(posedge sys_clk) deepSleepPin <= 1'b1;
    settle();
    checkBit("rise mode exit", 1'b0, deepSleepActive);
    wr(ADDR_POWERDOWN_CTRL, 32'h00);
    @(posedge sys_clk) sleepRequest <= 1'b1;
    settle();
    @(posedge sys_clk) deepSleepPin <= 1'b0;
    settle();
    checkBit("pin ignored", 1'b1, deepSleepActive);
    @(posedge sys_clk) sleepRequest <= 1'b0;
    settle();
    checkBit("request exit", 1'b0, deepSleepActive);
    rd(ADDR_EVENT_STATUS, 32'hc1, "sleep events");
    results();
  end
endmodule : tb

`default_nettype wire
